/* core/rio_ctrl.sv */
`timescale 1ns/1ps
module rio_ctrl
  import rio_pkg::*;
#(
  parameter int unsigned NPINS = RIO_NPINS
) (
  input  wire logic             clk,              // system clock
  input  wire logic             resetn,           // synchronous reset, active low
  input  wire logic             ext_reset_n,      // reset pin, async
  input  wire logic             por_ok,           // power-on detector: supply above threshold
  input  wire logic             supply_dip_ok,    // supply_dip_detector: core supply good
  input  wire rio_bus_t         bus,              // register bus request
  output logic [7:0]            rdata,            // read data, one cycle after rd
  input  wire logic             deep_sleep_mode_a,// deepest power mode a
  input  wire logic             deep_sleep_mode_b,// deepest power mode b
  input  wire logic             sleep_active,     // any sleep mode
  input  wire logic [NPINS-1:0] pin_in,           // pad input levels, async
  input  wire logic [NPINS-1:0] periph_out,       // peripheral output levels
  input  wire logic [NPINS-1:0] periph_oe,        // peripheral drive request, active high
  output rio_pad_t              pad,              // pad controls
  output logic [NPINS-1:0]      pin_sync,         // synchronised pin levels
  output logic                  wake_irq,         // wake interrupt level
  output logic                  low_supply_drive_select, // faster output drive for low io supply
  output logic                  sys_reset_n       // device reset, active low
);

  initial begin
    if (NPINS != RIO_NPINS) $error("rio_ctrl: NPINS must equal RIO_NPINS");
  end

  ////////////////////////////////////////////////////////////////////////
  // reset sources
  logic [2:0]       ext_sync_reg;
  logic [7:0]       ext_cnt_reg;
  logic [4:0]       stretch_reg;
  logic             ext_req;
  logic             fw_req_reg;
  logic             src_any;
  logic [3:0]       cause_reg;

  always_ff @(posedge clk) begin
    if (!resetn) ext_sync_reg <= 3'h7;
    else         ext_sync_reg <= {ext_sync_reg[1:0], ext_reset_n};
  end

  // pin low counts once two late stages agree, and only if low long enough
  always_ff @(posedge clk) begin
    if (!resetn) ext_cnt_reg <= 8'h00;
    else if (ext_sync_reg[2] | ext_sync_reg[1]) ext_cnt_reg <= 8'h00;
    else if (ext_cnt_reg != 8'(RIO_EXT_RST_CYC)) ext_cnt_reg <= ext_cnt_reg + 8'h01;
  end
  assign ext_req = (ext_cnt_reg == 8'(RIO_EXT_RST_CYC));

  assign src_any = ext_req | !por_ok | !supply_dip_ok | fw_req_reg;

  always_ff @(posedge clk) begin
    if (!resetn) stretch_reg <= 5'(RIO_RST_STRETCH);
    else if (src_any) stretch_reg <= 5'(RIO_RST_STRETCH);
    else if (stretch_reg != 5'h00) stretch_reg <= stretch_reg - 5'h01;
  end

  assign sys_reset_n = (stretch_reg == 5'h00) & !src_any;

  always_ff @(posedge clk) begin
    if (!resetn) cause_reg <= 4'h0;
    else if (src_any) begin
      cause_reg <= 4'h0;
      cause_reg[RIO_CAUSE_PIN] <= ext_req;
      cause_reg[RIO_CAUSE_POR] <= !por_ok;
      cause_reg[RIO_CAUSE_BOD] <= !supply_dip_ok;
      cause_reg[RIO_CAUSE_FW]  <= fw_req_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic             dev_rst;
  logic [NPINS-1:0] dir_reg;
  logic [NPINS-1:0] out_reg;
  logic [7:0]       pull_reg;
  logic [NPINS-1:0] func_reg;
  logic [3:0]       wake_cfg_reg;
  logic [1:0]       wstat_reg;
  logic             lsd_reg;
  logic             wr_dir, wr_out, wr_pull, wr_func, wr_wake, wr_wstat, wr_ctrl;

  assign dev_rst  = !resetn | !sys_reset_n;
  assign wr_dir   = bus.wr & (bus.addr == RIO_REG_DIR);
  assign wr_out   = bus.wr & (bus.addr == RIO_REG_OUT);
  assign wr_pull  = bus.wr & (bus.addr == RIO_REG_PULL);
  assign wr_func  = bus.wr & (bus.addr == RIO_REG_FUNC);
  assign wr_wake  = bus.wr & (bus.addr == RIO_REG_WAKE);
  assign wr_wstat = bus.wr & (bus.addr == RIO_REG_WSTAT);
  assign wr_ctrl  = bus.wr & (bus.addr == RIO_REG_CTRL);

  always_ff @(posedge clk) begin
    if (dev_rst) begin
      dir_reg  <= '0;
      pull_reg <= 8'h00;  // all pull-up
      func_reg <= '0;
      out_reg  <= '0;
    end else begin
      if (wr_dir)  dir_reg  <= bus.wdata[NPINS-1:0];
      if (wr_out)  out_reg  <= bus.wdata[NPINS-1:0];
      if (wr_pull) pull_reg <= bus.wdata;
      if (wr_func) func_reg <= bus.wdata[NPINS-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (dev_rst) begin
      wake_cfg_reg <= 4'h0;
      lsd_reg      <= 1'b0;
    end else begin
      if (wr_wake) wake_cfg_reg <= bus.wdata[3:0];
      if (wr_ctrl) lsd_reg      <= bus.wdata[RIO_CTRL_LSD_BIT];
    end
  end
  assign low_supply_drive_select = lsd_reg;

  // firmware reset request: held until the stretched reset clears it
  always_ff @(posedge clk) begin
    if (!resetn | (stretch_reg != 5'h00)) fw_req_reg <= 1'b0;
    else if (wr_ctrl & bus.wdata[RIO_CTRL_RST_BIT]) fw_req_reg <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // pin input sync and wake interrupts
  logic [NPINS-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
  logic [1:0]       wake_ev;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // level changes once stages two and three agree
  always_ff @(posedge clk) begin
    if (!resetn) lvl_reg <= '1;
    else         lvl_reg <= (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));
  end
  assign pin_sync = lvl_reg;

  // edges on pins 0 and 1; bit 2+i selects rising, else falling
  always_comb begin
    for (int i = 0; i < RIO_NWAKE; i++) begin
      wake_ev[i] = wake_cfg_reg[i] &
                   (wake_cfg_reg[i+2] ? (!lvl_reg[i] & s2_reg[i] & s3_reg[i])
                                      : (lvl_reg[i] & !s2_reg[i] & !s3_reg[i]));
    end
  end

  // set wins over write-one-to-clear
  always_ff @(posedge clk) begin
    if (dev_rst) wstat_reg <= 2'h0;
    else         wstat_reg <= (wstat_reg & ~({2{wr_wstat}} & bus.wdata[1:0])) | wake_ev;
  end
  assign wake_irq = |wstat_reg;

  ////////////////////////////////////////////////////////////////////////
  // pad drive with retention in deep modes
  logic             retain;
  logic [NPINS-1:0] eff_oe, eff_val;
  logic [NPINS-1:0] hold_oe_reg, hold_val_reg;

  assign retain  = deep_sleep_mode_a | deep_sleep_mode_b;
  assign eff_oe  = (func_reg & periph_oe)  | (~func_reg & dir_reg);
  assign eff_val = (func_reg & periph_out) | (~func_reg & out_reg);

  always_ff @(posedge clk) begin
    if (dev_rst) begin
      hold_oe_reg  <= '0;
      hold_val_reg <= '0;
    end else if (!retain) begin
      hold_oe_reg  <= eff_oe;
      hold_val_reg <= eff_val;
    end
  end

  function automatic logic pull_is(input logic [7:0] p, input int n, input rio_pull_t k);
    return p[2*n +: 2] == k;
  endfunction

  always_ff @(posedge clk) begin
    if (dev_rst) begin
      pad.out_val   <= '0;
      pad.out_en_n  <= '1;
      pad.pull_up   <= {{(NPINS-RIO_NHIGH){1'b1}}, {RIO_NHIGH{1'b0}}};
      pad.pull_down <= '0;
    end else begin
      for (int i = 0; i < NPINS; i++) begin
        logic oe;
        oe = retain ? hold_oe_reg[i] : eff_oe[i];
        pad.out_val[i]   <= retain ? hold_val_reg[i] : eff_val[i];
        pad.out_en_n[i]  <= !oe;
        pad.pull_up[i]   <= !oe & (i >= RIO_NHIGH) & pull_is(pull_reg, i, RIO_PULL_UP);
        pad.pull_down[i] <= !oe & (i >= RIO_NHIGH) & pull_is(pull_reg, i, RIO_PULL_DOWN);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read back
  always_ff @(posedge clk) begin
    if (!resetn) rdata <= 8'h00;
    else if (bus.rd) begin
      case (bus.addr)
        RIO_REG_DIR:    rdata <= 8'(dir_reg);
        RIO_REG_OUT:    rdata <= 8'(out_reg);
        RIO_REG_PULL:   rdata <= pull_reg;
        RIO_REG_FUNC:   rdata <= 8'(func_reg);
        RIO_REG_IN:     rdata <= 8'(lvl_reg);
        RIO_REG_WAKE:   rdata <= {4'h0, wake_cfg_reg};
        RIO_REG_WSTAT:  rdata <= {6'h00, wstat_reg};
        RIO_REG_CTRL:   rdata <= {6'h00, lsd_reg, 1'b0};
        RIO_REG_RCAUSE: rdata <= {4'h0, cause_reg};
        default:        rdata <= 8'h00;
      endcase
    end else rdata <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  reset_sources_a: assert property (!por_ok || !supply_dip_ok |-> !sys_reset_n)
    else $error("reset released while supply below threshold");
  fw_reset_a: assert property ($rose(fw_req_reg) |-> !sys_reset_n)
    else $error("firmware request did not reset");
  ext_reset_a: assert property (ext_req |-> !sys_reset_n)
    else $error("pin request did not reset");
  post_reset_a: assert property ($rose(sys_reset_n) |-> pad.out_en_n == '1 && pad.pull_up[NPINS-1:RIO_NHIGH] == '1)
    else $error("pins not input with pull-up after reset");
  high_nopull_a: assert property (pad.pull_up[RIO_NHIGH-1:0] == '0 && pad.pull_down[RIO_NHIGH-1:0] == '0)
    else $error("high-drive pin has a pull");
  drive_nopull_a: assert property ((~pad.out_en_n & (pad.pull_up | pad.pull_down)) == '0)
    else $error("pull active on a driven pin");
  retain_hold_a: assert property (retain && $past(retain) && sys_reset_n && $past(sys_reset_n)
                                   |-> $stable(pad.out_en_n) && $stable(pad.out_val))
    else $error("pin changed during deep mode");
  wake_set_a: assert property (sys_reset_n && wake_ev[0] |=> wstat_reg[0] && wake_irq)
    else $error("wake event lost");
  pull_sel_a: assert property (sys_reset_n && $past(sys_reset_n) && !$past(retain) && $past(!eff_oe[NPINS-1])
                               && $past(pull_is(pull_reg, NPINS-1, RIO_PULL_DOWN)) |-> pad.pull_down[NPINS-1])
    else $error("pull-down not applied");

  fw_reset_c:  cover property ($rose(fw_req_reg));
  wake_c:      cover property (wake_irq);
  retain_c:    cover property (retain [*3]);
  periph_c:    cover property (|func_reg && |periph_oe);

endmodule

/* core/rio_pkg.sv */
package rio_pkg;

  localparam int unsigned RIO_NPINS          = 4;   // general-purpose pins
  localparam int unsigned RIO_NHIGH          = 2;   // pins 0 and 1 are the high-drive pins
  localparam int unsigned RIO_NWAKE          = 2;   // pins able to raise wake interrupts
  localparam int unsigned RIO_CLK_MHZ        = 125;
  localparam int unsigned RIO_EXT_RST_MIN_NS = 250; // least reset pin low width
  localparam int unsigned RIO_EXT_RST_CYC    = (RIO_EXT_RST_MIN_NS * RIO_CLK_MHZ + 999) / 1000;
  localparam int unsigned RIO_RST_STRETCH    = 16;  // cycles reset stays asserted after all sources clear

  // register map
  localparam logic [3:0] RIO_REG_DIR     = 4'h0;  // 1 = output
  localparam logic [3:0] RIO_REG_OUT     = 4'h1;  // output levels
  localparam logic [3:0] RIO_REG_PULL    = 4'h2;  // two bits a pin: pull select
  localparam logic [3:0] RIO_REG_FUNC    = 4'h3;  // 1 = peripheral function
  localparam logic [3:0] RIO_REG_IN      = 4'h4;  // pin levels, read only
  localparam logic [3:0] RIO_REG_WAKE    = 4'h5;  // [1:0] enable, [3:2] rising edge select
  localparam logic [3:0] RIO_REG_WSTAT   = 4'h6;  // wake flags, write one to clear
  localparam logic [3:0] RIO_REG_CTRL    = 4'h7;  // [0] reset command, [1] low supply drive select
  localparam logic [3:0] RIO_REG_RCAUSE  = 4'h8;  // last reset cause

  localparam int unsigned RIO_CTRL_RST_BIT = 0;
  localparam int unsigned RIO_CTRL_LSD_BIT = 1;

  typedef enum logic [1:0] {
    RIO_PULL_UP   = 2'h0,
    RIO_PULL_DOWN = 2'h1,
    RIO_PULL_NONE = 2'h2
  } rio_pull_t;

  // reset cause bits
  localparam int unsigned RIO_CAUSE_PIN = 0;
  localparam int unsigned RIO_CAUSE_POR = 1;
  localparam int unsigned RIO_CAUSE_BOD = 2;
  localparam int unsigned RIO_CAUSE_FW  = 3;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rio_bus_t;

  typedef struct packed {
    logic [RIO_NPINS-1:0] out_val;
    logic [RIO_NPINS-1:0] out_en_n;
    logic [RIO_NPINS-1:0] pull_up;
    logic [RIO_NPINS-1:0] pull_down;
  } rio_pad_t;

endpackage

/* tb/rio_board.sv */
`timescale 1ns/1ps
module rio_board
  import rio_pkg::*;
(
  input  wire rio_pad_t   pad,      // pad controls from the port
  input  wire logic [3:0] ext_val,  // board level on unpulled, undriven pads
  output logic [3:0]      pin_level // resolved pad level
);
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!pad.out_en_n[i]) pin_level[i] = pad.out_val[i];
      else if (pad.pull_up[i]) pin_level[i] = 1'b1;
      else if (pad.pull_down[i]) pin_level[i] = 1'b0;
      else pin_level[i] = ext_val[i];
    end
  end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb_top
  import rio_pkg::*;
;
  logic clk = 0, resetn = 0, ext_reset_n = 1, por_ok = 1, supply_dip_ok = 1;
  logic dsa = 0, dsb = 0;
  logic [3:0] periph_out = 0, periph_oe = 0, ext_val = 0, pin_lvl, pin_sync;
  rio_bus_t bus = '0;
  rio_pad_t pad;
  logic [7:0] rdata, d;
  logic wake_irq, lsd, sys_reset_n;
  int bad_count = 0, tests_run = 0, cyc = 0;
  always #4 clk = ~clk;
  rio_ctrl i_dut (.clk(clk), .resetn(resetn), .ext_reset_n(ext_reset_n), .por_ok(por_ok),
    .supply_dip_ok(supply_dip_ok), .bus(bus), .rdata(rdata), .deep_sleep_mode_a(dsa),
    .deep_sleep_mode_b(dsb), .sleep_active(1'b0), .pin_in(pin_lvl), .periph_out(periph_out),
    .periph_oe(periph_oe), .pad(pad), .pin_sync(pin_sync), .wake_irq(wake_irq),
    .low_supply_drive_select(lsd), .sys_reset_n(sys_reset_n));
  rio_board i_board (.pad(pad), .ext_val(ext_val), .pin_level(pin_lvl));
  ////////////////////////////////////////////////////////////////////////////////
  task results();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end
  task cyc_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk) bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk) bus <= '0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) bus <= '0;
    #1 v = rdata;
  endtask
  task wait_up();
    int n;
    n = 0;
    while (sys_reset_n !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    `CHK("reset release", 1'b1, sys_reset_n)
    #1;
  endtask
  task chk_rst_pads();
    `CHK("reset drive", 4'hf, pad.out_en_n)
    `CHK("reset pullup", 4'hc, pad.pull_up)
    `CHK("reset pulldown", 4'h0, pad.pull_down)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc_n(2);
    resetn <= 1;
    cyc_n(2);
    #1 `CHK("stretch", 1'b0, sys_reset_n)
    wait_up();
    chk_rst_pads();
    $display("test reset done");
    for (int p = 0; p < 3; p++) begin
      ext_val <= 4'h1;
      wr(RIO_REG_PULL, {4{p[1:0]}});
      cyc_n(8);
      `CHK("pull up", (p == 0) ? 4'hc : 4'h0, pad.pull_up)
      `CHK("pull down", (p == 1) ? 4'hc : 4'h0, pad.pull_down)
      rd(RIO_REG_IN, d);
      `CHK("pin level", (p == 0) ? 4'hd : 4'h1, d[3:0])
      `CHK("pin sync", (p == 0) ? 4'hd : 4'h1, pin_sync)
    end
    $display("test pulls done");
    wr(RIO_REG_PULL, 8'h00);
    wr(RIO_REG_OUT, 8'h04);
    wr(RIO_REG_DIR, 8'h04);
    cyc_n(2);
    `CHK("drive", 4'hb, pad.out_en_n)
    `CHK("out level", 1'b1, pad.out_val[2])
    `CHK("pull off", 4'h8, pad.pull_up)
    for (int m = 0; m < 2; m++) begin
      dsa <= (m == 0);
      dsb <= (m == 1);
      wr(RIO_REG_OUT, 8'h00);
      wr(RIO_REG_DIR, 8'h00);
      cyc_n(3);
      `CHK("frozen drive", 4'hb, pad.out_en_n)
      `CHK("frozen level", 1'b1, pad.out_val[2])
      dsa <= 0;
      dsb <= 0;
      cyc_n(3);
      `CHK("thawed drive", 4'hf, pad.out_en_n)
      wr(RIO_REG_OUT, 8'h04);
      wr(RIO_REG_DIR, 8'h04);
      cyc_n(2);
    end
    $display("test retention done");
    wr(RIO_REG_FUNC, 8'h08);
    periph_oe <= 4'h8;
    periph_out <= 4'h8;
    cyc_n(3);
    `CHK("periph drive", 1'b0, pad.out_en_n[3])
    `CHK("periph level", 1'b1, pad.out_val[3])
    periph_out <= 4'h0;
    cyc_n(3);
    `CHK("periph low", 1'b0, pad.out_val[3])
    $display("test function done");
    ext_val <= 4'h0;
    wr(RIO_REG_WAKE, 8'h05);
    cyc_n(6);
    `CHK("wake idle", 1'b0, wake_irq)
    ext_val <= 4'h1;
    for (int n = 0; n < 20 && wake_irq !== 1'b1; n++) @(posedge clk);
    `CHK("wake raised", 1'b1, wake_irq)
    rd(RIO_REG_WSTAT, d);
    `CHK("wake flag", 1'b1, d[0])
    wr(RIO_REG_WSTAT, 8'h01);
    cyc_n(2);
    `CHK("wake cleared", 1'b0, wake_irq)
    rd(4'hf, d);
    `CHK("unmapped", 8'h00, d)
    wr(RIO_REG_CTRL, 8'h02);
    cyc_n(1);
    `CHK("low supply drive", 1'b1, lsd)
    $display("test wake done");
    for (int s = 0; s < 4; s++) begin
      wr(RIO_REG_DIR, 8'h04);
      case (s)
        0: ext_reset_n <= 0;
        1: por_ok <= 0;
        2: supply_dip_ok <= 0;
        default: wr(RIO_REG_CTRL, 8'h01);
      endcase
      cyc_n((s == 3) ? 4 : 40);
      `CHK("source reset", 1'b0, sys_reset_n)
      ext_reset_n <= 1;
      por_ok <= 1;
      supply_dip_ok <= 1;
      wait_up();
      chk_rst_pads();
      rd(RIO_REG_RCAUSE, d);
      `CHK("reset cause", 1'b1, d[s])
      rd(RIO_REG_DIR, d);
      `CHK("dir cleared", 8'h00, d)
    end
    $display("test sources done");
    results();
  end
endmodule
